/* File: verilog/usfrm_pkg.sv */
// shared constants, types and layouts for the serial frame-format block
package usfrm_pkg;

  // register indices on the plain register port
  localparam logic [2:0] ADDR_DATA = 3'h0;
  localparam logic [2:0] ADDR_STAT = 3'h1;
  localparam logic [2:0] ADDR_CTRLB = 3'h2;
  localparam logic [2:0] ADDR_CTRLC = 3'h3;
  localparam logic [2:0] ADDR_BAUDL = 3'h4;
  localparam logic [2:0] ADDR_BAUDH = 3'h5;

  // status register bit positions
  localparam int STAT_RXC = 7;
  localparam int STAT_TXC = 6;
  localparam int STAT_TXE = 5;
  localparam int STAT_FE = 4;
  localparam int STAT_OVR = 3;
  localparam int STAT_PE = 2;

  // ctrl_reg_b bit positions
  localparam int CTRLB_RXEN = 4;
  localparam int CTRLB_TXEN = 3;
  localparam int CTRLB_CSZ2 = 2;
  localparam int CTRLB_RXB8 = 1;
  localparam int CTRLB_TXB8 = 0;

  // ctrl_reg_c bit positions
  localparam int CTRLC_PM_HI = 5;
  localparam int CTRLC_PM_LO = 4;
  localparam int CTRLC_STOP2 = 3;
  localparam int CTRLC_CSZ_HI = 2;
  localparam int CTRLC_CSZ_LO = 1;

  // reset values and format encodings
  localparam logic [2:0] CSZ_RESET = 3'h3;
  localparam logic [2:0] CSZ_NINE = 3'h7;
  localparam logic [11:0] BAUD_RESET = 12'h000;
  localparam int BAUD_W = 12;

  // bit timing: sixteen baud ticks per bit, mid-bit at the eighth
  localparam logic [3:0] TICK_LAST = 4'hf;
  localparam logic [3:0] TICK_MID = 4'h7;

  // transmitter sequence
  typedef enum logic [2:0] {
    TX_IDLE = 3'b000,
    TX_START = 3'b001,
    TX_DATA = 3'b010,
    TX_PAR = 3'b011,
    TX_STOP1 = 3'b100,
    TX_STOP2 = 3'b101
  } usfrm_tx_type;

  // receiver sequence
  typedef enum logic [2:0] {
    RX_IDLE = 3'b000,
    RX_START = 3'b001,
    RX_DATA = 3'b010,
    RX_PAR = 3'b011,
    RX_STOP = 3'b100
  } usfrm_rx_type;

  // frame format shared by both directions
  typedef struct packed {
    logic [2:0] char_size_sel;
    logic [1:0] parity_mode_sel;
    logic stop2;
  } usfrm_format_type;

endpackage

/* File: verilog/usfrm_core.sv */
// serial frame-format transmitter and receiver with register port
// Summary of operation
// - accept all thirty start/data/parity/stop combinations
// - data bits go least significant first
// - parity bit sits between data and stop
// - start bit is driven low
// - every stop bit is driven high
// - line rests high between frames
// - next frame may start right after stop
// - both directions use one format setting
// - format change mid-frame may corrupt frames
// - data bit count from three-bit size field
// - two-bit parity field enables and picks parity
// - stop select chooses one or two stops
// - receiver checks only the first stop
// - frame error only when first stop low
// - even parity is xor of data bits
// - odd parity is inverted xor
// - stop select plus size three: 8N2
// - transmit-complete and receive-complete flags provided
// - size seven selects nine bits via bit8
// - parity only when upper parity bit set
// - baud counter reloads at zero or low write
//
// Our own choices: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
`default_nettype none

module usfrm_core
  import usfrm_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // register port
  input wire logic [2:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic we_i,
  input wire logic re_i,
  output logic [7:0] rdata_o,
  // serial line
  input wire logic serial_in_pin_i,
  output logic serial_out_pin_o,
  // status levels
  output logic tx_complete_flag_o,
  output logic rx_complete_flag_o
);

  // whole block state
  typedef struct packed {
    usfrm_format_type fmt;
    logic rx_en;
    logic tx_en;
    logic tx_b8;
    logic [BAUD_W-1:0] baud_div;
    logic [BAUD_W-1:0] baud_cnt;
    logic [8:0] tx_buf;
    logic tx_buf_full;
    logic tx_complete;
    usfrm_tx_type tx_state;
    logic [8:0] tx_shift;
    logic [3:0] tx_bit;
    logic [3:0] tx_tick;
    logic tx_par;
    logic serial_out;
    logic rx_sync1;
    logic rx_sync2;
    usfrm_rx_type rx_state;
    logic [3:0] rx_tick;
    logic [3:0] rx_bit;
    logic [8:0] rx_shift;
    logic rx_par_err;
    logic [8:0] rx_buf;
    logic rx_complete;
    logic frame_error;
    logic parity_error;
    logic overrun;
    logic [7:0] rd_data;
  } usfrm_state_type;

  usfrm_state_type r;
  usfrm_state_type next_r;

  // data bits per frame from the size field
  function automatic logic [3:0] data_bits(input logic [2:0] csz);
    case (csz)
      3'h0: data_bits = 4'h5;
      3'h1: data_bits = 4'h6;
      3'h2: data_bits = 4'h7;
      3'h3: data_bits = 4'h8;
      3'h7: data_bits = 4'h9;
      default: data_bits = 4'h8; // reserved codes behave as eight bits
    endcase
  endfunction

  // parity over only the bits the frame carries
  function automatic logic parity_of(input logic [8:0] d, input logic [2:0] csz,
                                     input logic odd);
    logic [8:0] mask;
    mask = 9'h1ff >> (4'h9 - data_bits(csz));
    parity_of = (^(d & mask)) ^ odd;
  endfunction

  logic baud_tick;
  logic par_on;
  logic [3:0] nbits;
  logic rx_line;

  // format decode shared by both directions
  assign baud_tick = (r.baud_cnt == '0);
  assign par_on = r.fmt.parity_mode_sel[1];
  assign nbits = data_bits(r.fmt.char_size_sel);
  assign rx_line = r.rx_sync2;

  // next-state logic for the whole block
  always_comb begin
    next_r = r;

    // baud down-counter, reloaded at zero or on a low-byte write
    if (we_i && addr_i == ADDR_BAUDL) begin
      next_r.baud_cnt = {r.baud_div[BAUD_W-1:8], wdata_i};
    end else if (baud_tick) begin
      next_r.baud_cnt = r.baud_div;
    end else begin
      next_r.baud_cnt = r.baud_cnt - 1'b1;
    end

    // configuration writes take effect at once, even mid-frame
    if (we_i) begin
      case (addr_i)
        ADDR_STAT: begin
          if (wdata_i[STAT_TXC]) begin
            next_r.tx_complete = 1'b0; // write one to clear
          end
        end
        ADDR_CTRLB: begin
          next_r.rx_en = wdata_i[CTRLB_RXEN];
          next_r.tx_en = wdata_i[CTRLB_TXEN];
          next_r.fmt.char_size_sel[2] = wdata_i[CTRLB_CSZ2];
          next_r.tx_b8 = wdata_i[CTRLB_TXB8];
        end
        ADDR_CTRLC: begin
          next_r.fmt.parity_mode_sel = wdata_i[CTRLC_PM_HI:CTRLC_PM_LO];
          next_r.fmt.stop2 = wdata_i[CTRLC_STOP2];
          next_r.fmt.char_size_sel[1:0] = wdata_i[CTRLC_CSZ_HI:CTRLC_CSZ_LO];
        end
        ADDR_BAUDL: next_r.baud_div[7:0] = wdata_i;
        ADDR_BAUDH: next_r.baud_div[BAUD_W-1:8] = wdata_i[BAUD_W-9:0];
        default: ;
      endcase
    end

    // reading the data buffer consumes the received character
    if (re_i && addr_i == ADDR_DATA) begin
      next_r.rx_complete = 1'b0;
    end

    // transmitter: sixteen baud ticks per bit
    if (baud_tick && r.tx_state != TX_IDLE) begin
      next_r.tx_tick = r.tx_tick + 1'b1;
    end
    case (r.tx_state)
      TX_IDLE: begin
        if (r.tx_en && r.tx_buf_full) begin
          next_r.tx_state = TX_START;
          next_r.tx_shift = r.tx_buf;
          next_r.tx_par = parity_of(r.tx_buf, r.fmt.char_size_sel,
                                    r.fmt.parity_mode_sel[0]);
          next_r.tx_buf_full = 1'b0;
          next_r.tx_tick = '0;
          next_r.tx_bit = '0;
        end
      end
      TX_START: begin
        if (baud_tick && r.tx_tick == TICK_LAST) begin
          next_r.tx_state = TX_DATA;
        end
      end
      TX_DATA: begin
        if (baud_tick && r.tx_tick == TICK_LAST) begin
          if (r.tx_bit == nbits - 4'h1) begin
            next_r.tx_state = par_on ? TX_PAR : TX_STOP1;
          end else begin
            next_r.tx_bit = r.tx_bit + 4'h1;
          end
        end
      end
      TX_PAR: begin
        if (baud_tick && r.tx_tick == TICK_LAST) begin
          next_r.tx_state = TX_STOP1;
        end
      end
      TX_STOP1, TX_STOP2: begin
        if (baud_tick && r.tx_tick == TICK_LAST) begin
          if (r.tx_state == TX_STOP1 && r.fmt.stop2) begin
            next_r.tx_state = TX_STOP2;
          end else if (r.tx_buf_full) begin
            // back-to-back frame, no idle gap
            next_r.tx_state = TX_START;
            next_r.tx_shift = r.tx_buf;
            next_r.tx_par = parity_of(r.tx_buf, r.fmt.char_size_sel,
                                      r.fmt.parity_mode_sel[0]);
            next_r.tx_buf_full = 1'b0;
            next_r.tx_bit = '0;
          end else begin
            next_r.tx_state = TX_IDLE;
            next_r.tx_complete = 1'b1;
          end
        end
      end
      default: next_r.tx_state = TX_IDLE;
    endcase

    // receiver: two-flop synchroniser on the pin
    next_r.rx_sync1 = serial_in_pin_i;
    next_r.rx_sync2 = r.rx_sync1;
    if (baud_tick && r.rx_state != RX_IDLE) begin
      next_r.rx_tick = r.rx_tick + 1'b1;
    end
    case (r.rx_state)
      RX_IDLE: begin
        if (r.rx_en && !rx_line) begin
          next_r.rx_state = RX_START;
          next_r.rx_tick = '0;
        end
      end
      RX_START: begin
        // confirm start at mid-bit, then sample once per bit time
        if (baud_tick && r.rx_tick == TICK_MID) begin
          if (rx_line) begin
            next_r.rx_state = RX_IDLE; // glitch, not a start bit
          end else begin
            next_r.rx_state = RX_DATA;
            next_r.rx_tick = '0;
            next_r.rx_bit = '0;
            next_r.rx_shift = '0;
          end
        end
      end
      RX_DATA: begin
        if (baud_tick && r.rx_tick == TICK_LAST) begin
          next_r.rx_shift[r.rx_bit] = rx_line;
          if (r.rx_bit == nbits - 4'h1) begin
            next_r.rx_state = par_on ? RX_PAR : RX_STOP;
            next_r.rx_par_err = 1'b0;
          end else begin
            next_r.rx_bit = r.rx_bit + 4'h1;
          end
        end
      end
      RX_PAR: begin
        if (baud_tick && r.rx_tick == TICK_LAST) begin
          next_r.rx_par_err = rx_line ^ parity_of(r.rx_shift, r.fmt.char_size_sel,
                                                  r.fmt.parity_mode_sel[0]);
          next_r.rx_state = RX_STOP;
        end
      end
      RX_STOP: begin
        // only the first stop is looked at; a second one reads as idle
        if (baud_tick && r.rx_tick == TICK_LAST) begin
          next_r.rx_state = RX_IDLE;
          next_r.rx_buf = r.rx_shift;
          next_r.frame_error = !rx_line;
          next_r.parity_error = r.rx_par_err;
          next_r.overrun = r.rx_complete;
          next_r.rx_complete = 1'b1;
        end
      end
      default: next_r.rx_state = RX_IDLE;
    endcase

    // data write after the shifter so a load cannot swallow it
    if (we_i && addr_i == ADDR_DATA) begin
      next_r.tx_buf = {r.tx_b8, wdata_i};
      next_r.tx_buf_full = 1'b1;
    end

    // registered line level follows the coming transmit state
    case (next_r.tx_state)
      TX_START: next_r.serial_out = 1'b0;
      TX_DATA: next_r.serial_out = next_r.tx_shift[next_r.tx_bit];
      TX_PAR: next_r.serial_out = next_r.tx_par;
      TX_STOP1, TX_STOP2: next_r.serial_out = 1'b1;
      default: next_r.serial_out = 1'b1;
    endcase

    // read data valid only in the cycle after the strobe
    next_r.rd_data = '0;
    if (re_i) begin
      case (addr_i)
        ADDR_DATA: next_r.rd_data = r.rx_buf[7:0];
        ADDR_STAT: begin
          next_r.rd_data[STAT_RXC] = r.rx_complete;
          next_r.rd_data[STAT_TXC] = r.tx_complete;
          next_r.rd_data[STAT_TXE] = !r.tx_buf_full;
          next_r.rd_data[STAT_FE] = r.frame_error;
          next_r.rd_data[STAT_OVR] = r.overrun;
          next_r.rd_data[STAT_PE] = r.parity_error;
        end
        ADDR_CTRLB: begin
          next_r.rd_data[CTRLB_RXEN] = r.rx_en;
          next_r.rd_data[CTRLB_TXEN] = r.tx_en;
          next_r.rd_data[CTRLB_CSZ2] = r.fmt.char_size_sel[2];
          next_r.rd_data[CTRLB_RXB8] = r.rx_buf[8];
          next_r.rd_data[CTRLB_TXB8] = r.tx_b8;
        end
        ADDR_CTRLC: begin
          next_r.rd_data[CTRLC_PM_HI:CTRLC_PM_LO] = r.fmt.parity_mode_sel;
          next_r.rd_data[CTRLC_STOP2] = r.fmt.stop2;
          next_r.rd_data[CTRLC_CSZ_HI:CTRLC_CSZ_LO] = r.fmt.char_size_sel[1:0];
        end
        ADDR_BAUDL: next_r.rd_data = r.baud_div[7:0];
        ADDR_BAUDH: next_r.rd_data[BAUD_W-9:0] = r.baud_div[BAUD_W-1:8];
        default: next_r.rd_data = '0;
      endcase
    end
  end

  // state register; line and synchroniser reset to idle high
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r <= '0;
      r.serial_out <= 1'b1;
      r.rx_sync1 <= 1'b1;
      r.rx_sync2 <= 1'b1;
      r.fmt.char_size_sel <= CSZ_RESET;
      r.baud_div <= BAUD_RESET;
    end else begin
      r <= next_r;
    end
  end

  // outputs straight from flip-flops
  assign rdata_o = r.rd_data;
  assign serial_out_pin_o = r.serial_out;
  assign tx_complete_flag_o = r.tx_complete;
  assign rx_complete_flag_o = r.rx_complete;

  // checks on frame shape and flags
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  idle_line_high_a: assert property (
    r.tx_state == TX_IDLE |-> serial_out_pin_o)
    else $error("line not high while idle");
  start_bit_low_a: assert property (
    $rose(r.tx_state == TX_START) |-> !serial_out_pin_o [*8])
    else $error("start bit not low");
  stop_bit_high_a: assert property (
    (r.tx_state == TX_STOP1 || r.tx_state == TX_STOP2) |-> serial_out_pin_o)
    else $error("stop bit not high");
  lsb_first_a: assert property (
    $rose(r.tx_state == TX_DATA) |-> r.tx_bit == 4'h0 && serial_out_pin_o == r.tx_shift[0])
    else $error("data not lsb first");
  parity_place_a: assert property (
    $rose(r.tx_state == TX_PAR) |-> $past(r.tx_state) == TX_DATA && par_on)
    else $error("parity bit misplaced");
  bit_count_a: assert property (
    $past(r.tx_state) == TX_DATA && r.tx_state != TX_DATA |-> $past(r.tx_bit) == nbits - 4'h1)
    else $error("wrong number of data bits");
  two_stop_a: assert property (
    $rose(r.tx_state == TX_STOP2) |-> $past(r.fmt.stop2))
    else $error("second stop without select");
  frame_err_a: assert property (
    $rose(r.frame_error) |-> $past(r.rx_state) == RX_STOP && !$past(r.rx_sync2))
    else $error("frame error without low stop");
  baud_reload_a: assert property (
    we_i && addr_i == ADDR_BAUDL |=> r.baud_cnt == {r.baud_div[BAUD_W-1:8], $past(wdata_i)})
    else $error("baud counter not reloaded");

  back_to_back_c: cover property ($past(r.tx_state) == TX_STOP1 && r.tx_state == TX_START);
  parity_frame_c: cover property (r.tx_state == TX_PAR);
  frame_error_c: cover property ($rose(r.frame_error));
  nine_bit_c: cover property (r.rx_state == RX_STOP && r.fmt.char_size_sel == CSZ_NINE);

endmodule

`default_nettype wire

/* File: tb/usfrm_remote.sv */
// far-end serial transceiver model sharing the frame format
`timescale 1ns/1ps
`default_nettype none

module usfrm_remote #(
  parameter int BIT_CLKS = 32
) (
  // clock
  input wire logic clk_i,
  // serial lines
  input wire logic line_i,
  output logic line_o,
  // frame format
  input wire logic [3:0] nbits_i,
  input wire logic par_en_i,
  input wire logic par_odd_i,
  input wire logic stop2_i
);
  logic [8:0] got_data;
  logic got_par;
  logic got_stop1;
  logic got_stop2;
  int got_count;

  // one bit time on the outgoing line
  task automatic put_bit(input logic b);
    line_o <= b;
    repeat (BIT_CLKS) @(posedge clk_i);
  endtask

  // send one frame; knobs spoil parity or the first stop
  task automatic send_frame(input logic [8:0] d, input logic bad_par, input logic bad_stop);
    logic p;
    p = par_odd_i;
    for (int i = 0; i < nbits_i; i++) p = p ^ d[i];
    @(posedge clk_i);
    put_bit(1'b0);
    for (int i = 0; i < nbits_i; i++) put_bit(d[i]);
    if (par_en_i) begin
      put_bit(p ^ bad_par);
    end
    // short low stop: covers mid-bit, then high so no false start follows
    if (bad_stop) begin
      line_o <= 1'b0;
      repeat (BIT_CLKS / 2 + 8) @(posedge clk_i);
    end
    put_bit(1'b1);
    if (stop2_i) begin
      put_bit(1'b1);
    end
    line_o <= 1'b1;
  endtask

  // receiver: mid-bit sampling of the block's transmit line
  initial begin
    line_o = 1'b1;
    got_count = 0;
    forever begin
      wait (line_i === 1'b1);
      @(negedge line_i);
      repeat (BIT_CLKS / 2) @(posedge clk_i);
      if (line_i === 1'b0) begin
        got_data = '0;
        for (int i = 0; i < nbits_i; i++) begin
          repeat (BIT_CLKS) @(posedge clk_i);
          got_data[i] = line_i;
        end
        if (par_en_i) begin
          repeat (BIT_CLKS) @(posedge clk_i);
          got_par = line_i;
        end
        repeat (BIT_CLKS) @(posedge clk_i);
        got_stop1 = line_i;
        got_stop2 = 1'b1;
        if (stop2_i) begin
          repeat (BIT_CLKS) @(posedge clk_i);
          got_stop2 = line_i;
        end
        got_count++;
      end
    end
  end
endmodule

`default_nettype wire

/* File: tb/tb.sv */
// self-checking bench for the frame-format block
`timescale 1ns/1ps
`default_nettype none

module tb;
  import usfrm_pkg::*;
  logic clk_i, rst_i, we_i, re_i, serial_in_pin_i, serial_out_pin_o;
  logic tx_complete_flag_o, rx_complete_flag_o;
  logic [2:0] addr_i;
  logic [7:0] wdata_i, rdata_o, v;
  logic [3:0] nbits;
  logic pen, podd, stop2;
  int fail_count, check_count;

  usfrm_core dut (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .we_i(we_i), .re_i(re_i), .rdata_o(rdata_o), .serial_in_pin_i(serial_in_pin_i),
    .serial_out_pin_o(serial_out_pin_o), .tx_complete_flag_o(tx_complete_flag_o),
    .rx_complete_flag_o(rx_complete_flag_o));

  // divider 1 gives 32 clocks a bit
  usfrm_remote #(.BIT_CLKS(32)) peer (.clk_i(clk_i), .line_i(serial_out_pin_o),
    .line_o(serial_in_pin_i), .nbits_i(nbits), .par_en_i(pen), .par_odd_i(podd),
    .stop2_i(stop2));

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  task automatic check(input logic [8:0] seen, input logic [8:0] exp, input string what);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_i);
    we_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clk_i);
    we_i <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk_i);
    re_i <= 1'b1;
    addr_i <= a;
    @(posedge clk_i);
    re_i <= 1'b0;
    @(negedge clk_i);
    d = rdata_o;
  endtask

  task automatic wait_peer(input int n);
    for (int k = 0; k < 3000 && peer.got_count < n; k++) @(posedge clk_i);
  endtask

  task automatic wait_txc();
    for (int k = 0; k < 200 && tx_complete_flag_o !== 1'b1; k++) @(posedge clk_i);
  endtask

  task automatic test_reset();
    check(serial_out_pin_o, 1'b1, "idle line");
    rd(ADDR_CTRLC, v);
    check(v, 8'h06, "format reset");
    rd(3'h6, v);
    check(v, 8'h00, "unmapped read");
    check({tx_complete_flag_o, rx_complete_flag_o}, 2'b00, "flags reset");
    // no interrupt sources here, so nothing to mask before set-up
    wr(ADDR_BAUDH, 8'h00);
    wr(ADDR_BAUDL, 8'h01);
  endtask

  // every size, parity and stop setting, both directions
  task automatic test_formats();
    logic [2:0] csz;
    logic [1:0] pm;
    logic [8:0] d, m;
    int nb, n0;
    for (int c = 0; c < 5; c++) begin
      for (int q = 0; q < 3; q++) begin
        for (int s = 0; s < 2; s++) begin
          csz = (c == 4) ? CSZ_NINE : 3'(c);
          pm = (q == 0) ? 2'b00 : 2'(q + 1);
          nb = (c == 4) ? 9 : c + 5;
          d = 9'(c * 97 + q * 41 + s * 200 + 5);
          m = 9'((1 << nb) - 1);
          nbits <= 4'(nb);
          pen <= pm[1];
          podd <= pm[0];
          stop2 <= s[0];
          // format only changes while both directions are quiet
          wr(ADDR_CTRLC, {2'b00, pm, s[0], csz[1:0], 1'b0});
          wr(ADDR_CTRLB, {3'b000, 2'b11, csz[2], 1'b0, d[8]});
          wr(ADDR_STAT, 8'h40);
          n0 = peer.got_count;
          wr(ADDR_DATA, d[7:0]);
          wait_peer(n0 + 1);
          // a frame that never arrives must not pass on stale peer data
          check(9'(peer.got_count - n0), 9'd1, "tx frame seen");
          check(peer.got_data, d & m, "tx data");
          if (pm[1]) begin
            check(peer.got_par, pm[0] ^ (^(d & m)), "tx parity");
          end
          check(peer.got_stop1, 1'b1, "tx stop");
          check(peer.got_stop2, 1'b1, "tx stop2");
          wait_txc();
          check(tx_complete_flag_o, 1'b1, "tx complete");
          peer.send_frame(d, 1'b0, 1'b0);
          check(rx_complete_flag_o, 1'b1, "rx complete");
          rd(ADDR_STAT, v);
          check({v[STAT_FE], v[STAT_PE]}, 2'b00, "rx errors");
          if (c == 4) begin
            rd(ADDR_CTRLB, v);
            check(v[CTRLB_RXB8], d[8], "rx ninth bit");
          end
          rd(ADDR_DATA, v);
          check(v, d[7:0] & m[7:0], "rx data");
          check(rx_complete_flag_o, 1'b0, "rx flag cleared");
        end
      end
    end
  endtask

  task automatic test_errors();
    nbits <= 4'd8;
    pen <= 1'b1;
    podd <= 1'b0;
    stop2 <= 1'b0;
    // size bit two is left set by the nine-bit pass; back to eight bits
    wr(ADDR_CTRLB, 8'h18);
    wr(ADDR_CTRLC, 8'h26);
    peer.send_frame(9'h0c3, 1'b0, 1'b1);
    rd(ADDR_STAT, v);
    check(v[STAT_FE], 1'b1, "frame error");
    rd(ADDR_DATA, v);
    peer.send_frame(9'h0c3, 1'b1, 1'b0);
    rd(ADDR_STAT, v);
    check({v[STAT_FE], v[STAT_PE]}, 2'b01, "parity error");
    rd(ADDR_DATA, v);
  endtask

  task automatic test_back2back();
    int n0;
    pen <= 1'b0;
    wr(ADDR_CTRLC, 8'h06);
    n0 = peer.got_count;
    wr(ADDR_STAT, 8'h40);
    wr(ADDR_DATA, 8'h5a);
    v = 8'h00;
    for (int k = 0; k < 100 && v[STAT_TXE] !== 1'b1; k++) rd(ADDR_STAT, v);
    check(v[STAT_TXE], 1'b1, "tx buffer free");
    wr(ADDR_DATA, 8'h3c);
    wait_peer(n0 + 2);
    check(9'(peer.got_count - n0), 9'd2, "frame count");
    check(peer.got_data, 9'h03c, "second frame");
    wait_txc();
    check(tx_complete_flag_o, 1'b1, "tx complete");
    wr(ADDR_STAT, 8'h40);
    @(negedge clk_i);
    check(tx_complete_flag_o, 1'b0, "tx complete cleared");
    check(serial_out_pin_o, 1'b1, "idle after");
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // watchdog: the whole sequence needs well under 40000 cycles
  initial begin
    repeat (80000) @(posedge clk_i);
    fail_count++;
    tally_and_finish();
  end

  initial begin
    rst_i = 1'b1;
    we_i = 1'b0;
    re_i = 1'b0;
    addr_i = 3'h0;
    wdata_i = 8'h00;
    nbits = 4'd8;
    pen = 1'b0;
    podd = 1'b0;
    stop2 = 1'b0;
    fail_count = 0;
    check_count = 0;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    test_reset();
    test_formats();
    test_errors();
    test_back2back();
    tally_and_finish();
  end
endmodule

`default_nettype wire
